//--- rtl/sirq_dev.sv
// Purpose: Slave agent of the serial interrupt line
// Assumes: Line and irq inputs synchronous to ref_clk
// Notes:   rstn is the bus reset; all outputs registered

`timescale 1ns/10ps

module sirq_dev #(
	parameter int NUM_IRQ = sirq_pkg::NUM_IRQ
) (
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	sirq_if.dev                     link,
	input  wire logic [NUM_IRQ-1:0] irq_in,
	output logic                    quiet_mode,
	output logic                    cycle_active,
	output logic                    start_pending,
	output logic [NUM_IRQ-1:0]      irq_sent
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		D_IDLE   = 2'h0,
		D_START  = 2'h1,
		D_FRAMES = 2'h2,
		D_STOP   = 2'h3
	} sirq_dstate_t;

	typedef struct packed {
		sirq_dstate_t                   state;
		logic                           wait_rise;
		sirq_pkg::sirq_phase_t          phase;
		logic [sirq_pkg::FRAME_W-1:0]   frame;
		logic [2:0]                     low_run;
		logic                           quiet;
		logic                           drove_low;
		logic                           drv;
		logic                           oe;
		logic                           active;
		logic                           pending;
		logic [NUM_IRQ-1:0]             sent;
	} sirq_dev_st_t;

	sirq_dev_st_t st_ff;
	sirq_dev_st_t nxt_st;

	logic                         line;
	logic                         change;
	logic [sirq_pkg::FRAME_W-1:0] frame_inc;

	assign line      = link.serirq;
	assign change    = |(irq_in ^ st_ff.sent);
	assign frame_inc = (st_ff.frame == sirq_pkg::FRAME_MAX) ?
		st_ff.frame : st_ff.frame + 6'h01;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pending = change;

		// Length of the current low run, saturating
		if (line) begin
			nxt_st.low_run = 3'h0;
		end else if (st_ff.low_run != sirq_pkg::LOW_RUN_MAX) begin
			nxt_st.low_run = st_ff.low_run + 3'h1;
		end

		unique case (st_ff.state)
		D_IDLE: begin
			nxt_st.oe     = 1'b0;
			nxt_st.drv    = 1'b1;
			nxt_st.active = 1'b0;
			if (!line) begin
				// Someone else began a start frame
				nxt_st.state     = D_FRAMES;
				nxt_st.wait_rise = 1'b1;
				nxt_st.active    = 1'b1;
			end else if (st_ff.quiet && change) begin
				// First idle clock after a stop only decides, so the
				// pulse lands two clocks after the stop rise
				nxt_st.state     = D_START;
				nxt_st.oe        = 1'b1;
				nxt_st.drv       = 1'b0;
				nxt_st.active    = 1'b1;
			end
		end

		D_START: begin
			// Exactly one low clock, then float; never drive high
			nxt_st.oe        = 1'b0;
			nxt_st.drv       = 1'b1;
			nxt_st.state     = D_FRAMES;
			nxt_st.wait_rise = 1'b1;
		end

		D_FRAMES: begin
			if (st_ff.wait_rise) begin
				// Host holds the line low; frame count starts at rise
				if (line) begin
					nxt_st.wait_rise = 1'b0;
					nxt_st.phase     = sirq_pkg::PH_TURN;
					nxt_st.frame     = '0;
				end
			end else begin
				unique case (st_ff.phase)
				sirq_pkg::PH_TURN: begin
					nxt_st.phase     = sirq_pkg::PH_SAMP;
					nxt_st.frame     = frame_inc;
					nxt_st.drove_low = 1'b0;
					nxt_st.oe        = 1'b0;
					nxt_st.drv       = 1'b1;
					for (int i = 0; i < NUM_IRQ; i++) begin
						if (frame_inc == sirq_pkg::FRAME_W'(i + 1)) begin
							// Deliver the level seen now and remember it
							nxt_st.sent[i] = irq_in[i];
							if (!irq_in[i]) begin
								nxt_st.oe        = 1'b1;
								nxt_st.drv       = 1'b0;
								nxt_st.drove_low = 1'b1;
							end
						end
					end
				end
				sirq_pkg::PH_SAMP: begin
					nxt_st.phase = sirq_pkg::PH_RECV;
					// Recovery high only after a sample low
					nxt_st.oe    = st_ff.drove_low;
					nxt_st.drv   = 1'b1;
				end
				sirq_pkg::PH_RECV: begin
					nxt_st.phase = sirq_pkg::PH_TURN;
					nxt_st.oe    = 1'b0;
					nxt_st.drv   = 1'b1;
					// Nobody drives low in recovery except a stop frame
					if (!line) begin
						nxt_st.state = D_STOP;
					end
				end
				default: begin
					nxt_st.phase = sirq_pkg::PH_TURN;
					nxt_st.oe    = 1'b0;
				end
				endcase
			end
		end

		D_STOP: begin
			nxt_st.oe  = 1'b0;
			nxt_st.drv = 1'b1;
			if (line) begin
				// Width known at the stop rise; only place mode moves
				nxt_st.quiet  = (st_ff.low_run ==
					sirq_pkg::STOP_QUIET_CLKS);
				nxt_st.state  = D_IDLE;
				nxt_st.active = 1'b0;
			end
		end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_ff      <= '0;
			st_ff.drv  <= 1'b1;
			st_ff.oe   <= 1'b0;
			st_ff.quiet <= 1'b0;
			// Inputs idle high: nothing pending until one goes low
			st_ff.sent <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign link.dev_oe   = st_ff.oe;
	assign link.dev_drv  = st_ff.drv;
	assign quiet_mode    = st_ff.quiet;
	assign cycle_active  = st_ff.active;
	assign start_pending = st_ff.pending;
	assign irq_sent      = st_ff.sent;

endmodule

//--- rtl/sirq_pkg.sv
// Purpose: Shared constants and types for the serial interrupt link
// Assumes: One slave end and one host end on a single shared line
// Notes:   Every figure used by both ends lives here

package sirq_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int          NUM_IRQ     = 16;
	localparam int          FRAME_W     = 6;
	localparam int          HOST_FRAMES = 17;
	localparam logic [5:0]  FRAME_MAX   = 6'h3F;

	// ---------------------------------------------------------------
	// Pulse widths in clocks
	// ---------------------------------------------------------------
	localparam logic [2:0]  STOP_QUIET_CLKS = 3'h2;
	localparam logic [2:0]  STOP_CONT_CLKS  = 3'h3;
	localparam logic [2:0]  START_EXT_MIN   = 3'h3;
	localparam logic [2:0]  START_EXT_MAX   = 3'h7;
	localparam logic [2:0]  LOW_RUN_MAX     = 3'h7;

	// ---------------------------------------------------------------
	// Data frame phases
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_SAMP = 2'h0,
		PH_RECV = 2'h1,
		PH_TURN = 2'h2
	} sirq_phase_t;

endpackage

//--- rtl/sirq_if.sv
// Purpose: Shared serial interrupt line between slave and host ends
// Assumes: Line is pulled high when nobody drives it
// Notes:   Low wins when two parties drive at once

`timescale 1ns/10ps

interface sirq_if;
	logic serirq;
	logic dev_drv;
	logic dev_oe;
	logic host_drv;
	logic host_oe;

	// Resolved level with pull-up
	assign serirq = ((dev_oe & ~dev_drv) | (host_oe & ~host_drv)) ?
		1'b0 : 1'b1;

	modport dev (
		input  serirq,
		output dev_drv,
		output dev_oe
	);

	modport host (
		input  serirq,
		output host_drv,
		output host_oe
	);
endinterface

//--- rtl/sirq_host.sv
// Purpose: Host controller end of the serial interrupt line
// Assumes: Line synchronous to ref_clk; user inputs are levels
// Notes:   rstn is the bus reset; all outputs registered

`timescale 1ns/10ps

module sirq_host #(
	parameter int NUM_IRQ    = sirq_pkg::NUM_IRQ,
	parameter int NUM_FRAMES = sirq_pkg::HOST_FRAMES
) (
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	sirq_if.host                    link,
	input  wire logic               start_req,
	input  wire logic               quiet_req,
	input  wire logic [2:0]         start_ext,
	output logic [NUM_IRQ-1:0]      irq_level,
	output logic                    quiet_mode,
	output logic                    busy,
	output logic                    cycle_done
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		H_IDLE       = 3'h0,
		H_START_LOW  = 3'h1,
		H_START_HIGH = 3'h2,
		H_FRAMES     = 3'h3,
		H_STOP_LOW   = 3'h4,
		H_STOP_HIGH  = 3'h5
	} sirq_hstate_t;

	typedef struct packed {
		sirq_hstate_t                   state;
		sirq_pkg::sirq_phase_t          phase;
		logic [sirq_pkg::FRAME_W-1:0]   frame;
		logic [3:0]                     cnt;
		logic                           quiet;
		logic                           quiet_nxt;
		logic                           drv;
		logic                           oe;
		logic                           busy;
		logic                           done;
		logic [NUM_IRQ-1:0]             level;
	} sirq_host_st_t;

	sirq_host_st_t st_ff;
	sirq_host_st_t nxt_st;

	logic       line;
	logic [2:0] ext;

	assign line = link.serirq;
	// Out-of-range settings clamp into three to seven
	assign ext  = (start_ext < sirq_pkg::START_EXT_MIN) ?
		sirq_pkg::START_EXT_MIN : start_ext;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;

		unique case (st_ff.state)
		H_IDLE: begin
			nxt_st.oe   = 1'b0;
			nxt_st.drv  = 1'b1;
			nxt_st.busy = 1'b0;
			// Slave starts only honoured in quiet mode
			if (start_req || (st_ff.quiet && !line)) begin
				nxt_st.state = H_START_LOW;
				nxt_st.oe    = 1'b1;
				nxt_st.drv   = 1'b0;
				nxt_st.busy  = 1'b1;
				// A slave start supplies the first low clock itself
				nxt_st.cnt   = line ? {1'b0, ext} + 4'h1 : {1'b0, ext};
			end
		end
		H_START_LOW: begin
			nxt_st.cnt = st_ff.cnt - 4'h1;
			if (st_ff.cnt == 4'h1) begin
				nxt_st.state = H_START_HIGH;
				nxt_st.drv   = 1'b1;
			end
		end
		H_START_HIGH: begin
			nxt_st.state = H_FRAMES;
			nxt_st.oe    = 1'b0;
			nxt_st.phase = sirq_pkg::PH_TURN;
			nxt_st.frame = '0;
		end
		H_FRAMES: begin
			unique case (st_ff.phase)
			sirq_pkg::PH_TURN: begin
				if (st_ff.frame == sirq_pkg::FRAME_W'(NUM_FRAMES)) begin
					nxt_st.state     = H_STOP_LOW;
					nxt_st.oe        = 1'b1;
					nxt_st.drv       = 1'b0;
					nxt_st.quiet_nxt = quiet_req;
					nxt_st.cnt       = quiet_req ?
						{1'b0, sirq_pkg::STOP_QUIET_CLKS} :
						{1'b0, sirq_pkg::STOP_CONT_CLKS};
				end else begin
					nxt_st.phase = sirq_pkg::PH_SAMP;
					nxt_st.frame = st_ff.frame + 6'h01;
				end
			end
			sirq_pkg::PH_SAMP: begin
				nxt_st.phase = sirq_pkg::PH_RECV;
				for (int i = 0; i < NUM_IRQ; i++) begin
					if (st_ff.frame == sirq_pkg::FRAME_W'(i + 1)) begin
						nxt_st.level[i] = line;
					end
				end
			end
			sirq_pkg::PH_RECV: begin
				nxt_st.phase = sirq_pkg::PH_TURN;
			end
			default: begin
				nxt_st.phase = sirq_pkg::PH_TURN;
			end
			endcase
		end
		H_STOP_LOW: begin
			nxt_st.cnt = st_ff.cnt - 4'h1;
			if (st_ff.cnt == 4'h1) begin
				nxt_st.state = H_STOP_HIGH;
				nxt_st.drv   = 1'b1;
			end
		end
		H_STOP_HIGH: begin
			nxt_st.state = H_IDLE;
			nxt_st.oe    = 1'b0;
			nxt_st.quiet = st_ff.quiet_nxt;
			nxt_st.done  = 1'b1;
		end
		default: begin
			nxt_st.state = H_IDLE;
			nxt_st.oe    = 1'b0;
		end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_ff       <= '0;
			st_ff.drv   <= 1'b1;
			st_ff.oe    <= 1'b0;
			st_ff.level <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign link.host_oe  = st_ff.oe;
	assign link.host_drv = st_ff.drv;
	assign irq_level     = st_ff.level;
	assign quiet_mode    = st_ff.quiet;
	assign busy          = st_ff.busy;
	assign cycle_done    = st_ff.done;

endmodule

//--- testbench/sirq_checker.sv
// Purpose: Concurrent checks on the shared serial interrupt line
// Assumes: One slave end and one host end, line pulled high
// Notes:   Sees the interface signals only

`timescale 1ns/10ps

module sirq_checker (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic serirq,
	input wire logic dev_drv,
	input wire logic dev_oe,
	input wire logic host_drv,
	input wire logic host_oe
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	logic [3:0] low_run_ff;
	logic       seen_host_ff;

	// Saturate so a stuck line cannot wrap back to a legal count
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			low_run_ff   <= 4'h0;
			seen_host_ff <= 1'b0;
		end else begin
			low_run_ff   <= serirq ? 4'h0 :
				low_run_ff + {3'h0, low_run_ff != 4'hF};
			seen_host_ff <= seen_host_ff | host_oe;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// ---------------------------------------------------------------
	// Sequences and properties
	// ---------------------------------------------------------------
	sequence s_host_takes;
		host_oe && !host_drv && !dev_oe;
	endsequence
	sequence s_dev_recovers;
		dev_oe && dev_drv && !host_oe;
	endsequence

	property p_rst_quiet;
		disable iff (1'b0) !rstn |=> !dev_oe && !host_oe;
	endproperty
	property p_dev_high;
		dev_oe && dev_drv |-> $past(dev_oe) && !$past(dev_drv);
	endproperty
	property p_dev_low;
		dev_oe && !dev_drv |=> s_host_takes or s_dev_recovers;
	endproperty
	property p_dev_turn;
		dev_oe && dev_drv |=> !dev_oe;
	endproperty
	property p_host_high;
		host_oe && host_drv |=> !host_oe;
	endproperty
	property p_low_max;
		low_run_ff <= 4'h8;
	endproperty
	property p_host_first;
		dev_oe |-> seen_host_ff;
	endproperty
	property p_gap_after_rise;
		host_oe && host_drv |=> !dev_oe;
	endproperty

	a_rst_quiet: assert property (p_rst_quiet)
		else $error("line driven during bus reset");
	a_dev_high: assert property (p_dev_high)
		else $error("slave drove high without a prior low");
	a_dev_low: assert property (p_dev_low)
		else $error("slave low not followed by takeover or recovery");
	a_dev_turn: assert property (p_dev_turn)
		else $error("slave kept driving in turnaround");
	a_host_high: assert property (p_host_high)
		else $error("host high longer than one clock");
	a_low_max: assert property (p_low_max)
		else $error("line low for more than eight clocks");
	a_host_first: assert property (p_host_first)
		else $error("slave drove before any host cycle");
	a_gap_after_rise: assert property (p_gap_after_rise)
		else $error("slave drove right after a host high clock");
endmodule

//--- testbench/serial_interrupt_agent_tb.sv
// Purpose: Self-checking bench for slave and host ends back to back
// Assumes: Default sizes, 16 interrupt inputs
// Notes:   Model holds expected vectors in a queue

`timescale 1ns/10ps

module serial_interrupt_agent_tb;
	logic        ref_clk, rstn, start_req, quiet_req;
	logic [2:0]  start_ext;
	logic [15:0] irq_in, irq_sent, irq_level, v;
	logic        dev_quiet, dev_active, dev_pend;
	logic        host_quiet, host_busy, cycle_done;
	int          mismatches, comparisons, cyc, exp_quiet, busy_seen;
	logic [15:0] exp_q[$];

	sirq_if link_if();
	sirq_dev sirq_dev_inst (.ref_clk(ref_clk), .rstn(rstn),
		.link(link_if), .irq_in(irq_in), .quiet_mode(dev_quiet),
		.cycle_active(dev_active), .start_pending(dev_pend),
		.irq_sent(irq_sent));
	sirq_host sirq_host_inst (.ref_clk(ref_clk), .rstn(rstn),
		.link(link_if), .start_req(start_req), .quiet_req(quiet_req),
		.start_ext(start_ext), .irq_level(irq_level),
		.quiet_mode(host_quiet), .busy(host_busy),
		.cycle_done(cycle_done));
	sirq_checker sirq_checker_inst (.ref_clk(ref_clk), .rstn(rstn),
		.serirq(link_if.serirq), .dev_drv(link_if.dev_drv),
		.dev_oe(link_if.dev_oe), .host_drv(link_if.host_drv),
		.host_oe(link_if.host_oe));

	always #4 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		comparisons++;
		if (got !== want) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic conclude();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Bounded wait for the stop frame, then delivered data and mode
	task automatic await_cycle();
		int n;
		n = 0;
		while (cycle_done !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 400) mismatches++;
		repeat (2) @(negedge ref_clk);
		chk(irq_level, exp_q.pop_front());
		chk({15'h0, dev_quiet}, 16'(exp_quiet));
		chk({15'h0, host_quiet}, 16'(exp_quiet));
	endtask

	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		start_req = 1'b0;
		quiet_req = 1'b0;
		start_ext = 3'h3;
		irq_in = 16'hFFFF;
		void'($urandom(32'h081B));
		repeat (10) @(posedge ref_clk);
		chk({15'h0, link_if.serirq}, 16'h1);
		rstn <= 1'b1;
		@(negedge ref_clk);
		chk({15'h0, dev_quiet}, 16'h0);
		chk(irq_sent, 16'hFFFF);
		// Back-to-back cycles, every start width, both stop widths
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			v = 16'($urandom);
			start_ext <= 3'(i + 1);
			quiet_req <= i[0];
			start_req <= 1'b1;
			irq_in <= v;
			exp_q.push_back(v);
			exp_quiet = i % 2;
			await_cycle();
		end
		@(posedge ref_clk);
		start_req <= 1'b0;
		repeat (150) @(posedge ref_clk);
		// Quiet mode: slave starts its own cycles on input change
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			v = irq_in ^ (16'($urandom) | 16'h1);
			irq_in <= v;
			exp_q.push_back(v);
			await_cycle();
			chk(irq_sent, v);
		end
		// Back to continuous, then a change must wait for the host
		@(posedge ref_clk);
		quiet_req <= 1'b0;
		start_req <= 1'b1;
		exp_q.push_back(irq_in);
		exp_quiet = 0;
		@(posedge ref_clk);
		start_req <= 1'b0;
		await_cycle();
		@(posedge ref_clk);
		v = ~irq_in;
		irq_in <= v;
		busy_seen = 0;
		repeat (100) begin
			@(negedge ref_clk);
			if (host_busy !== 1'b0) busy_seen++;
		end
		chk(16'(busy_seen), 16'h0);
		chk({15'h0, dev_pend}, 16'h1);
		chk({15'h0, dev_active}, 16'h0);
		@(posedge ref_clk);
		start_req <= 1'b1;
		exp_q.push_back(v);
		@(posedge ref_clk);
		start_req <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({15'h0, dev_active}, 16'h1);
		await_cycle();
		// Bus reset in mid-cycle, then a clean cycle after release
		@(posedge ref_clk);
		start_req <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b0;
		start_req <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({15'h0, link_if.serirq}, 16'h1);
		chk({14'h0, dev_active, host_busy}, 16'h0);
		chk(irq_level, 16'hFFFF);
		chk(irq_sent, 16'hFFFF);
		@(posedge ref_clk);
		rstn <= 1'b1;
		start_req <= 1'b1;
		exp_q.push_back(irq_in);
		@(posedge ref_clk);
		start_req <= 1'b0;
		await_cycle();
		conclude();
	end
endmodule
